// *** rtl/gpc_pkg.sv ***
package gpc_pkg;
    localparam int          ADDR_W   = 18;
    localparam int          DATA_W   = 32;
    localparam int          NSLOT    = 8;
    localparam logic [15:0] IDX_NONE = 16'h0000;

    // Slots hold ports 0,1,2,3,5,7,8,9 in that order
    localparam int          SLOT_W   [NSLOT] = '{4, 2, 7, 4, 4, 3, 2, 8};
    localparam logic [15:0] IDX_DAT  [NSLOT] = '{16'hff00, 16'hff01, 16'hff02, 16'hff03,
                                                 16'hff05, 16'hff07, 16'hff08, 16'hff09};
    localparam logic [15:0] IDX_DIR  [NSLOT] = '{16'hff20, 16'hff21, 16'hff22, 16'hff23,
                                                 16'hff25, 16'hff27, 16'hff28, 16'hff29};
    localparam logic [15:0] IDX_PUB  [NSLOT] = '{IDX_NONE, IDX_NONE, 16'hff32, 16'hff33,
                                                 IDX_NONE, 16'hff37, 16'hff38, 16'hff39};
    localparam int          SLOT_OD      = 4;
    localparam int          SLOT_LARGE   = 6;
    localparam logic [15:0] IDX_DAT6     = 16'hff06;
    localparam logic [15:0] IDX_PU0      = 16'hfff7;

    // Shared pull-up option register fields
    localparam int          PU0_P0_BIT   = 0;
    localparam int          PU0_P1_BIT   = 1;
    localparam logic [1:0]  PU0_RST      = 2'h0;

    // Reset values
    localparam logic [7:0]  DIR_RST      = 8'hff;
    localparam logic [7:0]  PUB_RST      = 8'h00;
    localparam logic [7:0]  LAT_RST      = 8'h00;
endpackage

// *** rtl/gpc_port_slice.sv ***
`timescale 1ns/10ps
module gpc_port_slice
    import gpc_pkg::*;
#(
    parameter int W          = 8,
    parameter bit HAS_PUB    = 1'b1,
    parameter bit OPEN_DRAIN = 1'b0
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    // Register writes
    input  wire logic         wr_dat_in,
    input  wire logic         wr_dir_in,
    input  wire logic         wr_pub_in,
    input  wire logic [7:0]   wdat_in,
    // Pin side and alternate function
    input  wire logic [W-1:0] pin_in,
    input  wire logic [W-1:0] grp_pu_in,
    input  wire logic [W-1:0] alt_sel_in,
    input  wire logic [W-1:0] alt_do_in,
    // Register read values
    output logic      [7:0]   rd_dat_out,
    output logic      [7:0]   rd_dir_out,
    output logic      [7:0]   rd_pub_out,
    // Pin drive
    output logic      [W-1:0] do_out,
    output logic      [W-1:0] oe_n_out,
    output logic      [W-1:0] pu_out
);
    logic [W-1:0] dir_ff;
    logic [W-1:0] lat_ff;
    logic [W-1:0] pub_ff;
    logic [W-1:0] do_ff;
    logic [W-1:0] oe_n_ff;
    logic [W-1:0] pu_ff;
    logic [W-1:0] out_mode;
    logic [W-1:0] pu_sel;
    logic [W-1:0] src;
    logic [W-1:0] nxt_do;
    logic [W-1:0] nxt_oe_n;
    logic [W-1:0] nxt_pu;

    assign out_mode = ~dir_ff;
    // Own register or shared group bit
    assign pu_sel   = HAS_PUB ? pub_ff : grp_pu_in;
    assign src      = (alt_sel_in & alt_do_in) | (~alt_sel_in & lat_ff);
    assign nxt_do   = OPEN_DRAIN ? '0 : src;
    assign nxt_oe_n = OPEN_DRAIN ? ~(out_mode & ~src) : ~out_mode;
    assign nxt_pu   = pu_sel & dir_ff;

    // Pin in input, latch in output
    assign rd_dat_out = 8'((dir_ff & pin_in) | (out_mode & lat_ff));
    // Unimplemented direction bits read as one
    assign rd_dir_out = ~8'(out_mode);
    assign rd_pub_out = HAS_PUB ? 8'(pub_ff) : 8'h00;

    // Registered pin drive
    assign do_out   = do_ff;
    assign oe_n_out = oe_n_ff;
    assign pu_out   = pu_ff;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dir_ff <= DIR_RST[W-1:0];
        end else if (wr_dir_in) begin
            dir_ff <= wdat_in[W-1:0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lat_ff <= LAT_RST[W-1:0];
        end else if (wr_dat_in) begin
            lat_ff <= wdat_in[W-1:0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pub_ff <= PUB_RST[W-1:0];
        end else if (wr_pub_in && HAS_PUB) begin
            pub_ff <= wdat_in[W-1:0];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            do_ff   <= '0;
            oe_n_ff <= '1;
            pu_ff   <= '0;
        end else begin
            do_ff   <= nxt_do;
            oe_n_ff <= nxt_oe_n;
            pu_ff   <= nxt_pu;
        end
    end
endmodule

// *** rtl/gpc_top.sv ***
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/10ps
module gpc_top
    import gpc_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // Clock and reset
    input  wire logic                      CLK_SYS_IN,
    input  wire logic                      RST_N_IN,
    // Wishbone slave
    input  wire logic                      WB_CYC_IN,
    input  wire logic                      WB_STB_IN,
    input  wire logic                      WB_WE_IN,
    input  wire logic [gpc_pkg::ADDR_W-1:0] WB_ADR_IN,
    input  wire logic [3:0]                WB_SEL_IN,
    input  wire logic [gpc_pkg::DATA_W-1:0] WB_DAT_IN,
    output logic      [gpc_pkg::DATA_W-1:0] WB_DAT_OUT,
    output logic                           WB_ACK_OUT,
    // Port 0
    input  wire logic [3:0]                PORT0_PIN_IN,
    output logic      [3:0]                PORT0_DO_OUT,
    output logic      [3:0]                PORT0_OE_N_OUT,
    output logic      [3:0]                PORT0_PU_OUT,
    // Port 1
    input  wire logic [1:0]                PORT1_PIN_IN,
    output logic      [1:0]                PORT1_DO_OUT,
    output logic      [1:0]                PORT1_OE_N_OUT,
    output logic      [1:0]                PORT1_PU_OUT,
    // Port 2 and its alternate outputs
    input  wire logic [6:0]                PORT2_PIN_IN,
    input  wire logic [6:0]                PORT2_ALT_SEL_IN,
    input  wire logic [6:0]                PORT2_ALT_DO_IN,
    output logic      [6:0]                PORT2_DO_OUT,
    output logic      [6:0]                PORT2_OE_N_OUT,
    output logic      [6:0]                PORT2_PU_OUT,
    // Port 3 and its alternate outputs
    input  wire logic [3:0]                PORT3_PIN_IN,
    input  wire logic [3:0]                PORT3_ALT_SEL_IN,
    input  wire logic [3:0]                PORT3_ALT_DO_IN,
    output logic      [3:0]                PORT3_DO_OUT,
    output logic      [3:0]                PORT3_OE_N_OUT,
    output logic      [3:0]                PORT3_PU_OUT,
    output logic      [3:0]                PORT3_ALT_PIN_OUT,
    // Port 5, open drain
    input  wire logic [3:0]                PORT5_PIN_IN,
    output logic      [3:0]                PORT5_DO_OUT,
    output logic      [3:0]                PORT5_OE_N_OUT,
    // Port 6, input only
    input  wire logic [5:0]                PORT6_PIN_IN,
    output logic      [5:0]                ANALOG_IN_OUT,
    // Port 7
    input  wire logic [2:0]                PORT7_PIN_IN,
    output logic      [2:0]                PORT7_DO_OUT,
    output logic      [2:0]                PORT7_OE_N_OUT,
    output logic      [2:0]                PORT7_PU_OUT,
    // Port 8
    input  wire logic [1:0]                PORT8_PIN_IN,
    output logic      [1:0]                PORT8_DO_OUT,
    output logic      [1:0]                PORT8_OE_N_OUT,
    output logic      [1:0]                PORT8_PU_OUT,
    // Port 9
    input  wire logic [7:0]                PORT9_PIN_IN,
    output logic      [7:0]                PORT9_DO_OUT,
    output logic      [7:0]                PORT9_OE_N_OUT,
    output logic      [7:0]                PORT9_PU_OUT
);
    import gpc_pkg::*;

    // Per-slot vectors, padded to a byte
    logic [7:0]        pin_v     [NSLOT];
    logic [7:0]        grp_v     [NSLOT];
    logic [7:0]        alt_sel_v [NSLOT];
    logic [7:0]        alt_do_v  [NSLOT];
    logic [7:0]        do_v      [NSLOT];
    logic [7:0]        oe_n_v    [NSLOT];
    logic [7:0]        pu_v      [NSLOT];
    logic [7:0]        rd_dat_v  [NSLOT];
    logic [7:0]        rd_dir_v  [NSLOT];
    logic [7:0]        rd_pub_v  [NSLOT];
    logic [NSLOT-1:0]  hit_dat;
    logic [NSLOT-1:0]  hit_dir;
    logic [NSLOT-1:0]  hit_pub;
    logic [NSLOT-1:0]  present;

    // Bus state
    logic              ack_ff;
    logic [DATA_W-1:0] rdat_ff;
    logic [1:0]        pu0_ff;
    logic [5:0]        ana_ff;
    logic [3:0]        p3_alt_ff;
    logic [15:0]       idx;
    logic              req;
    logic              wr_go;
    logic              rd_go;
    logic              hit_pu0;
    logic              hit_dat6;
    logic [7:0]        rd_mux;

    // Bus decode: one register per word
    assign idx      = WB_ADR_IN[ADDR_W-1:2];
    assign req      = WB_CYC_IN & WB_STB_IN;
    // Write lands on the edge where ack is seen high
    assign wr_go    = req & ack_ff & WB_WE_IN & WB_SEL_IN[0];
    assign rd_go    = req & ~ack_ff;
    assign hit_pu0  = (idx == IDX_PU0);
    assign hit_dat6 = (idx == IDX_DAT6);

    // Pack pins into slots
    assign pin_v[0] = {4'h0, PORT0_PIN_IN};
    assign pin_v[1] = {6'h00, PORT1_PIN_IN};
    assign pin_v[2] = {1'b0, PORT2_PIN_IN};
    assign pin_v[3] = {4'h0, PORT3_PIN_IN};
    assign pin_v[4] = {4'h0, PORT5_PIN_IN};
    assign pin_v[5] = {5'h00, PORT7_PIN_IN};
    assign pin_v[6] = {6'h00, PORT8_PIN_IN};
    assign pin_v[7] = PORT9_PIN_IN;

    // Whole first port follows one bit
    assign grp_v[0] = {4'h0, {4{pu0_ff[PU0_P0_BIT]}}};
    // Second port pair follows one bit
    assign grp_v[1] = {6'h00, {2{pu0_ff[PU0_P1_BIT]}}};
    // Other slots take no shared bit; open drain has no pull-up source
    assign grp_v[2] = 8'h00;
    assign grp_v[3] = 8'h00;
    assign grp_v[4] = 8'h00;
    assign grp_v[5] = 8'h00;
    assign grp_v[6] = 8'h00;
    assign grp_v[7] = 8'h00;

    // Serial, buzzer, timer outputs on third and fourth ports
    assign alt_sel_v[2] = {1'b0, PORT2_ALT_SEL_IN};
    assign alt_do_v[2]  = {1'b0, PORT2_ALT_DO_IN};
    assign alt_sel_v[3] = {4'h0, PORT3_ALT_SEL_IN};
    assign alt_do_v[3]  = {4'h0, PORT3_ALT_DO_IN};
    assign alt_sel_v[0] = 8'h00;
    assign alt_do_v[0]  = 8'h00;
    assign alt_sel_v[1] = 8'h00;
    assign alt_do_v[1]  = 8'h00;
    assign alt_sel_v[4] = 8'h00;
    assign alt_do_v[4]  = 8'h00;
    assign alt_sel_v[5] = 8'h00;
    assign alt_do_v[5]  = 8'h00;
    assign alt_sel_v[6] = 8'h00;
    assign alt_do_v[6]  = 8'h00;
    assign alt_sel_v[7] = 8'h00;
    assign alt_do_v[7]  = 8'h00;

    // One slice per latched port
    for (genvar k = 0; k < NSLOT; k++) begin : g_slot
        localparam int W   = SLOT_W[k];
        localparam bit HPU = (IDX_PUB[k] != IDX_NONE);

        // Last two slots exist on large variant only
        assign present[k] = (k < SLOT_LARGE) || LARGE_VARIANT;
        // Data and direction registers per port, pull-up where the slot has one
        assign hit_dat[k] = present[k] && (idx == IDX_DAT[k]);
        assign hit_dir[k] = present[k] && (idx == IDX_DIR[k]);
        assign hit_pub[k] = present[k] && HPU && (idx == IDX_PUB[k]);

        gpc_port_slice #(
            .W          (W),
            .HAS_PUB    (HPU),
            .OPEN_DRAIN (k == SLOT_OD)
        ) u_slice (
            .clk_in     (CLK_SYS_IN),
            .rst_n_in   (RST_N_IN),
            .wr_dat_in  (wr_go & hit_dat[k]),
            .wr_dir_in  (wr_go & hit_dir[k]),
            .wr_pub_in  (wr_go & hit_pub[k]),
            .wdat_in    (WB_DAT_IN[7:0]),
            .pin_in     (pin_v[k][W-1:0]),
            .grp_pu_in  (grp_v[k][W-1:0]),
            .alt_sel_in (alt_sel_v[k][W-1:0]),
            .alt_do_in  (alt_do_v[k][W-1:0]),
            .rd_dat_out (rd_dat_v[k]),
            .rd_dir_out (rd_dir_v[k]),
            .rd_pub_out (rd_pub_v[k]),
            .do_out     (do_v[k][W-1:0]),
            .oe_n_out   (oe_n_v[k][W-1:0]),
            .pu_out     (pu_v[k][W-1:0])
        );
        if (W < 8) begin : g_pad
            assign do_v[k][7:W]   = '0;
            assign oe_n_v[k][7:W] = '1;
            assign pu_v[k][7:W]   = '0;
        end
    end

    // Read mux; unmapped words read zero
    always_comb begin
        rd_mux = 8'h00;
        for (int k = 0; k < NSLOT; k++) begin
            if (hit_dat[k]) begin
                rd_mux = rd_dat_v[k];
            end
            if (hit_dir[k]) begin
                rd_mux = rd_dir_v[k];
            end
            if (hit_pub[k]) begin
                rd_mux = rd_pub_v[k];
            end
        end
        if (hit_pu0) begin
            rd_mux = {6'h00, pu0_ff};
        end
        // Input-only port read straight from pins
        if (hit_dat6) begin
            rd_mux = {2'b00, PORT6_PIN_IN};
        end
    end

    // Registered ack, dropped the cycle after it is given
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= rd_go;
        end
    end

    // Read data caught as ack rises, held while it stands
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rdat_ff <= '0;
        end else if (rd_go) begin
            rdat_ff <= DATA_W'(rd_mux);
        end
    end

    // Shared pull-up bits cleared at reset; upper bits not stored
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            pu0_ff <= PU0_RST;
        end else if (wr_go && hit_pu0) begin
            pu0_ff <= WB_DAT_IN[1:0];
        end
    end

    // Analog inputs of input-only port and input functions of fourth port see registered pins
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ana_ff    <= '0;
            p3_alt_ff <= '0;
        end else begin
            ana_ff    <= PORT6_PIN_IN;
            p3_alt_ff <= PORT3_PIN_IN;
        end
    end

    // Outputs
    assign WB_ACK_OUT        = ack_ff;
    assign WB_DAT_OUT        = rdat_ff;
    assign ANALOG_IN_OUT     = ana_ff;
    assign PORT3_ALT_PIN_OUT = p3_alt_ff;

    // Unpack slots to pins
    assign PORT0_DO_OUT   = do_v[0][3:0];
    assign PORT0_OE_N_OUT = oe_n_v[0][3:0];
    assign PORT0_PU_OUT   = pu_v[0][3:0];
    assign PORT1_DO_OUT   = do_v[1][1:0];
    assign PORT1_OE_N_OUT = oe_n_v[1][1:0];
    assign PORT1_PU_OUT   = pu_v[1][1:0];
    assign PORT2_DO_OUT   = do_v[2][6:0];
    assign PORT2_OE_N_OUT = oe_n_v[2][6:0];
    assign PORT2_PU_OUT   = pu_v[2][6:0];
    assign PORT3_DO_OUT   = do_v[3][3:0];
    assign PORT3_OE_N_OUT = oe_n_v[3][3:0];
    assign PORT3_PU_OUT   = pu_v[3][3:0];
    assign PORT5_DO_OUT   = do_v[4][3:0];
    assign PORT5_OE_N_OUT = oe_n_v[4][3:0];
    assign PORT7_DO_OUT   = do_v[5][2:0];
    assign PORT7_OE_N_OUT = oe_n_v[5][2:0];
    assign PORT7_PU_OUT   = pu_v[5][2:0];
    assign PORT8_DO_OUT   = do_v[6][1:0];
    assign PORT8_OE_N_OUT = oe_n_v[6][1:0];
    assign PORT8_PU_OUT   = pu_v[6][1:0];
    assign PORT9_DO_OUT   = do_v[7];
    assign PORT9_OE_N_OUT = oe_n_v[7];
    assign PORT9_PU_OUT   = pu_v[7];
endmodule

// *** verif/gpc_board_pins.sv ***
`timescale 1ns/10ps
module gpc_board_pins #(
    parameter int W = 8
) (
    // Clock for the floating pattern
    input  wire logic         clk_in,
    // Board drive
    input  wire logic         en_in,
    input  wire logic [W-1:0] ext_in,
    // Port drive
    input  wire logic [W-1:0] oe_n_in,
    input  wire logic [W-1:0] do_in,
    input  wire logic [W-1:0] pu_in,
    // Resolved pin level
    output logic      [W-1:0] pin_out
);
    logic [W-1:0] flt_ff = '0;
    // Undriven pins toggle, so a stale level never passes for a real one
    always @(posedge clk_in) begin
        flt_ff <= ~flt_ff;
    end
    // Port drive wins, then the board, then the pull-up, else floating
    assign pin_out = (~oe_n_in & do_in) | (oe_n_in & (en_in ? ext_in : (pu_in | flt_ff)));
endmodule

// *** verif/gpc_top_asserts.sv ***
`timescale 1ns/10ps
module gpc_top_asserts
    import gpc_pkg::*;
(
    // Clock and reset
    input wire logic                       CLK_SYS_IN,
    input wire logic                       RST_N_IN,
    // Wishbone
    input wire logic                       WB_CYC_IN,
    input wire logic                       WB_STB_IN,
    input wire logic                       WB_WE_IN,
    input wire logic [gpc_pkg::ADDR_W-1:0] WB_ADR_IN,
    input wire logic [3:0]                 WB_SEL_IN,
    input wire logic [gpc_pkg::DATA_W-1:0] WB_DAT_IN,
    input wire logic [gpc_pkg::DATA_W-1:0] WB_DAT_OUT,
    input wire logic                       WB_ACK_OUT,
    // Pins
    input wire logic [3:0]                 PORT0_OE_N_OUT,
    input wire logic [3:0]                 PORT0_PU_OUT,
    input wire logic [7:0]                 PORT9_OE_N_OUT,
    input wire logic [7:0]                 PORT9_PU_OUT,
    input wire logic [3:0]                 PORT5_DO_OUT,
    input wire logic [3:0]                 PORT3_PIN_IN,
    input wire logic [3:0]                 PORT3_ALT_PIN_OUT
);
    default clocking @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!RST_N_IN);
    // Request taken, and direction writes to the first port
    wire take_req = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
    wire dir0_wr  = take_req & WB_WE_IN & WB_SEL_IN[0] & (WB_ADR_IN[17:2] == IDX_DIR[0]);
    // Pin outputs lag the register by one cycle, so direction shows three edges on
    chk_ack_pulse: assert property (take_req |=> WB_ACK_OUT ##1 !WB_ACK_OUT)
        else $error("ack not a single pulse after a request");
    chk_ack_cause: assert property (WB_ACK_OUT |-> $past(take_req))
        else $error("ack without a request");
    chk_rd_upper: assert property (WB_ACK_OUT |-> WB_DAT_OUT[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    chk_dir_drive: assert property (
        dir0_wr |-> ##3 PORT0_OE_N_OUT == $past(WB_DAT_IN[3:0], 3))
        else $error("first port drive enable does not follow direction write");
    chk_pu_input: assert property (
        !(|(PORT0_PU_OUT & ~PORT0_OE_N_OUT)) && !(|(PORT9_PU_OUT & ~PORT9_OE_N_OUT)))
        else $error("pull-up connected on a driven pin");
    chk_pu_group: assert property (
        PORT0_PU_OUT == 4'h0 || PORT0_PU_OUT == PORT0_OE_N_OUT)
        else $error("first port pull-ups not switched as a group");
    chk_od_release: assert property (PORT5_DO_OUT == 4'h0)
        else $error("open-drain port drives high");
    chk_reset_input: assert property (
        $rose(RST_N_IN) |-> (&PORT0_OE_N_OUT) && (&PORT9_OE_N_OUT) && PORT9_PU_OUT == 8'h0)
        else $error("pins not released by reset");
    chk_alt_copy: assert property (
        $past(RST_N_IN) |-> PORT3_ALT_PIN_OUT == $past(PORT3_PIN_IN))
        else $error("fourth port alternate input copy wrong");
    // Main scenarios reached
    cov_write: cover property (take_req && WB_WE_IN);
    cov_read: cover property (take_req && !WB_WE_IN);
    cov_pullup: cover property (|PORT9_PU_OUT);
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
    import gpc_pkg::*;
    // Clock, reset and bus master
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [17:0] adr = '0;
    logic [31:0] wdat = '0;
    logic [3:0]  sel = '0;
    logic [3:0]  sel_req = 4'hf;
    logic [31:0] rdat, q;
    logic        ack;
    // Board side and port outputs
    logic        ext_en = 1'b1;
    logic [7:0]  ext = '0;
    logic [6:0]  alt_sel = '0;
    logic [6:0]  alt_do = '0;
    logic [5:0]  analog;
    logic [3:0]  p0_pin, p0_do, p0_oe_n, p0_pu, p3_do, p3_oe_n, p3_pu, p3_alt;
    logic [3:0]  p5_pin, p5_do, p5_oe_n;
    logic [1:0]  p1_do, p1_oe_n, p1_pu, p8_do, p8_oe_n, p8_pu;
    logic [6:0]  p2_do, p2_oe_n, p2_pu;
    logic [2:0]  p7_do, p7_oe_n, p7_pu;
    logic [7:0]  p9_pin, p9_do, p9_oe_n, p9_pu;
    int          err_total = 0;
    int          num_checks = 0;
    int          cycles = 0;
    // Free-running system clock
    always #5 clk = ~clk;
    // Block under test
    gpc_top i_gpc_top (
        .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
        .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
        .WB_ACK_OUT(ack), .PORT0_PIN_IN(p0_pin), .PORT0_DO_OUT(p0_do),
        .PORT0_OE_N_OUT(p0_oe_n), .PORT0_PU_OUT(p0_pu), .PORT1_PIN_IN(ext[1:0]),
        .PORT1_DO_OUT(p1_do), .PORT1_OE_N_OUT(p1_oe_n), .PORT1_PU_OUT(p1_pu),
        .PORT2_PIN_IN(ext[6:0]), .PORT2_ALT_SEL_IN(alt_sel), .PORT2_ALT_DO_IN(alt_do),
        .PORT2_DO_OUT(p2_do), .PORT2_OE_N_OUT(p2_oe_n), .PORT2_PU_OUT(p2_pu),
        .PORT3_PIN_IN(ext[3:0]), .PORT3_ALT_SEL_IN(alt_sel[3:0]), .PORT3_ALT_DO_IN(alt_do[3:0]),
        .PORT3_DO_OUT(p3_do), .PORT3_OE_N_OUT(p3_oe_n), .PORT3_PU_OUT(p3_pu),
        .PORT3_ALT_PIN_OUT(p3_alt), .PORT5_PIN_IN(p5_pin), .PORT5_DO_OUT(p5_do),
        .PORT5_OE_N_OUT(p5_oe_n), .PORT6_PIN_IN(ext[5:0]), .ANALOG_IN_OUT(analog),
        .PORT7_PIN_IN(ext[2:0]), .PORT7_DO_OUT(p7_do), .PORT7_OE_N_OUT(p7_oe_n),
        .PORT7_PU_OUT(p7_pu), .PORT8_PIN_IN(ext[1:0]), .PORT8_DO_OUT(p8_do),
        .PORT8_OE_N_OUT(p8_oe_n), .PORT8_PU_OUT(p8_pu), .PORT9_PIN_IN(p9_pin),
        .PORT9_DO_OUT(p9_do), .PORT9_OE_N_OUT(p9_oe_n), .PORT9_PU_OUT(p9_pu)
    );
    // Board wiring of the pins that are read back; open drain has no pull-up
    gpc_board_pins #(.W(4)) i_brd0 (.clk_in(clk), .en_in(ext_en), .ext_in(ext[3:0]),
        .oe_n_in(p0_oe_n), .do_in(p0_do), .pu_in(p0_pu), .pin_out(p0_pin));
    gpc_board_pins #(.W(4)) i_brd5 (.clk_in(clk), .en_in(ext_en), .ext_in(ext[3:0]),
        .oe_n_in(p5_oe_n), .do_in(p5_do), .pu_in(4'h0), .pin_out(p5_pin));
    gpc_board_pins #(.W(8)) i_brd9 (.clk_in(clk), .en_in(ext_en), .ext_in(ext),
        .oe_n_in(p9_oe_n), .do_in(p9_do), .pu_in(p9_pu), .pin_out(p9_pin));
    // Compare, bus cycle and verdict helpers
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb_go(input logic w, input logic [15:0] idx, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= sel_req;
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [15:0] idx, input logic [31:0] m, input logic [31:0] e);
        wb_go(1'b0, idx, 8'h00);
        cmp($sformatf("reg %h", idx), e, q & m);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Hang guard, far above the some 140 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            give_verdict();
        end
    end
    // Test sequence; pins are looked at mid-cycle, after their register edge
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int s = 0; s < NSLOT; s++) begin
            rd(IDX_DIR[s], '1, 32'hff);
            if (IDX_PUB[s] != IDX_NONE)
                rd(IDX_PUB[s], '1, 32'h0);
        end
        rd(IDX_PU0, '1, 32'h0);
        $display("test reset values done");
        ext <= 8'h05;
        wb_go(1'b1, IDX_DAT[0], 8'h0a);
        rd(IDX_DAT[0], 32'hf, 32'h5);
        wb_go(1'b1, IDX_DIR[0], 8'hfc);
        @(negedge clk);
        cmp("p0 oe_n", 32'hc, 32'(p0_oe_n));
        cmp("p0 do", 32'h2, 32'(p0_do & 4'h3));
        @(posedge clk);
        rd(IDX_DAT[0], 32'hf, 32'h6);
        $display("test latch and direction done");
        ext_en <= 1'b0;
        wb_go(1'b1, IDX_PU0, 8'hff);
        rd(IDX_PU0, '1, 32'h3);
        rd(IDX_DAT[0], 32'hf, 32'he);
        for (int s = 0; s < NSLOT; s++)
            if (IDX_PUB[s] != IDX_NONE)
                wb_go(1'b1, IDX_PUB[s], 8'hff);
        rd(IDX_PUB[2], 32'h7f, 32'h7f);
        wb_go(1'b1, IDX_DIR[7], 8'hf0);
        @(negedge clk);
        cmp("p0 pu", 32'hc, 32'(p0_pu));
        cmp("p1 pu", 32'h3, 32'(p1_pu));
        cmp("p2 pu", 32'h7f, 32'(p2_pu));
        cmp("p3 pu", 32'hf, 32'(p3_pu));
        cmp("p7 pu", 32'h7, 32'(p7_pu));
        cmp("p8 pu", 32'h3, 32'(p8_pu));
        cmp("p9 pu", 32'hf0, 32'(p9_pu));
        @(posedge clk);
        rd(IDX_DAT[7], 32'hff, 32'hf0);
        // Write without the low byte lane must leave the shared bits alone
        sel_req = 4'he;
        wb_go(1'b1, IDX_PU0, 8'h00);
        sel_req = 4'hf;
        rd(IDX_PU0, '1, 32'h3);
        $display("test pull-ups done");
        wb_go(1'b1, IDX_DAT[4], 8'h05);
        wb_go(1'b1, IDX_DIR[4], 8'hf0);
        @(negedge clk);
        cmp("p5 oe_n", 32'h5, 32'(p5_oe_n));
        cmp("p5 do", 32'h0, 32'(p5_do));
        @(posedge clk);
        rd(IDX_DAT[4], 32'hf, 32'h5);
        $display("test open drain done");
        ext_en <= 1'b1;
        ext <= 8'h2a;
        wb_go(1'b1, IDX_DAT6, 8'h00);
        rd(IDX_DAT6, 32'h3f, 32'h2a);
        @(negedge clk);
        cmp("analog", 32'h2a, 32'(analog));
        cmp("p3 alt", 32'ha, 32'(p3_alt));
        @(posedge clk);
        wb_go(1'b1, IDX_DAT[2], 8'h00);
        wb_go(1'b1, IDX_DIR[2], 8'hbf);
        // Low bit reaches the fourth port's alternate path, top bit the third's
        alt_sel <= 7'h41;
        alt_do <= 7'h41;
        repeat (2) @(posedge clk);
        @(negedge clk);
        cmp("p2 do", 32'h40, 32'(p2_do & 7'h40));
        cmp("p2 pu", 32'h3f, 32'(p2_pu));
        cmp("p3 do", 32'h1, 32'(p3_do));
        @(posedge clk);
        $display("test input port and alternate done");
        wb_go(1'b1, 16'h1234, 8'h55);
        rd(16'h1234, '1, 32'h0);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(IDX_DIR[7], '1, 32'hff);
        rd(IDX_PUB[2], '1, 32'h0);
        @(negedge clk);
        cmp("p9 oe_n", 32'hff, 32'(p9_oe_n));
        $display("test unmapped and second reset done");
        give_verdict();
    end
endmodule

bind gpc_top gpc_top_asserts i_gpc_top_asserts (
    .CLK_SYS_IN, .RST_N_IN, .WB_CYC_IN, .WB_STB_IN, .WB_WE_IN, .WB_ADR_IN, .WB_SEL_IN,
    .WB_DAT_IN, .WB_DAT_OUT, .WB_ACK_OUT, .PORT0_OE_N_OUT, .PORT0_PU_OUT, .PORT9_OE_N_OUT,
    .PORT9_PU_OUT, .PORT5_DO_OUT, .PORT3_PIN_IN, .PORT3_ALT_PIN_OUT
);
